// ===== logic/eil_pin_sync.sv
// Two-stage synchroniser and falling-edge detector for the interrupt pin.
// Assumes the pin is asynchronous to REF_CLK_IN; it idles high.
`timescale 1ns/1ns
module eil_pin_sync
   import eil_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic pin_b_in,
   output logic level_out,
   output logic fall_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } eil_sync_t;
   eil_sync_t st, next_st;

   always_comb begin
      next_st = st;
      if (ce_in) begin
         next_st.s1 = pin_b_in;
         next_st.s2 = st.s1;
         next_st.prev = st.s2;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st <= '{EIL_PIN_IDLE, EIL_PIN_IDLE, EIL_PIN_IDLE};
      end else begin
         st <= next_st;
      end
   end

   assign level_out = st.s2;
   // Edge taken from the second stage only; the first stage stays metastability-isolated
   assign fall_out = st.prev & ~st.s2;

   // A frozen chain keeps its edge flag, so only edges right after a live cycle are checked
   AST_FALL_PAIR: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      ($past(ce_in) && fall_out) |-> ($past(level_out) && !level_out))
      else $error("fall seen without high to low sample");
endmodule

// ===== logic/eil_pkg.sv
// Package for the external interrupt pin latch: offsets, field positions, reset values, bus and CPU types.
// Assumes a byte-wide register port with word offsets chosen below.
package eil_pkg;
   localparam int unsigned EIL_ADDR_W = 4;
   localparam int unsigned EIL_DATA_W = 8;
   localparam logic [3:0] EIL_OFF_STATUS_CONTROL = 4'h0;
   localparam logic [3:0] EIL_OFF_CONFIG = 4'h1;
   localparam logic [3:0] EIL_OFF_IRQ_STATUS = 4'h2;
   localparam logic [3:0] EIL_OFF_IRQ_MASK = 4'h3;
   localparam logic [3:0] EIL_OFF_PORT = 4'h4;
   // Status and control field positions
   localparam int unsigned EIL_BIT_MODE = 0;
   localparam int unsigned EIL_BIT_MASK = 1;
   localparam int unsigned EIL_BIT_ACK = 2;
   localparam int unsigned EIL_BIT_PEND = 3;
   // Config field positions
   localparam int unsigned EIL_BIT_FEN = 0;
   localparam int unsigned EIL_BIT_BREAK_CLEAR_ENABLE = 1;
   // Event bit positions
   localparam int unsigned EIL_EV_LATCH = 0;
   localparam int unsigned EIL_EV_CLEAR = 1;
   localparam logic [1:0] EIL_EV_RESET = 2'h0;
   localparam logic [7:0] EIL_RD_RESET = 8'h00;
   localparam logic EIL_PIN_IDLE = 1'b1;

   typedef struct packed {
      logic [EIL_ADDR_W-1:0] addr;
      logic [EIL_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } eil_bus_t;

   typedef struct packed {
      logic vector_fetch;
      logic break_state;
   } eil_cpu_t;

   function automatic logic eil_hit(input eil_bus_t b, input logic [3:0] off);
      return b.addr == off;
   endfunction
endpackage

// ===== logic/eil_regs.sv
// Event status and mask registers with a level interrupt output.
// Assumes one-cycle write strobes; events are one-cycle pulses.
`timescale 1ns/1ns
module eil_regs
   import eil_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   input wire logic [1:0] ev_in,
   input wire logic st_clr_wr_in,
   input wire logic mask_wr_in,
   input wire logic [1:0] wdata_in,
   output logic [1:0] status_out,
   output logic [1:0] mask_out,
   output logic irq_out
);
   typedef struct packed {
      logic [1:0] status;
      logic [1:0] mask;
      logic irq;
   } eil_ev_t;
   eil_ev_t st, next_st;

   always_comb begin
      next_st = st;
      if (ce_in) begin
         // Set wins over a simultaneous write-one clear
         next_st.status = (st.status & ~(st_clr_wr_in ? wdata_in : 2'h0)) | ev_in;
         if (mask_wr_in) begin
            next_st.mask = wdata_in;
         end
         next_st.irq = |(next_st.status & next_st.mask);
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st <= '{EIL_EV_RESET, EIL_EV_RESET, 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign status_out = st.status;
   assign mask_out = st.mask;
   assign irq_out = st.irq;
endmodule

// ===== logic/eil_top.sv
// Top of the external interrupt pin latch: request latch, sensitivity control, mask, register port.
// Assumes a synchronous byte register port and one-cycle vector-fetch pulses from the CPU.
`timescale 1ns/1ns
// Overview of operation
// - Pin function only when enable bit set
// - Falling edge sets the request latch
// - Vector fetch acknowledge clears the latch
// - Writing one to acknowledge clears latch
// - Any reset clears the latch
// - Edge-only after reset; mode bit selects level
// - Edge mode: request holds until acknowledged
// - Level mode: needs acknowledge and pin high
// - Level mode: pending while pin stays low
// - Reset clears latch and mode bit
// - Module mask withholds request from CPU
// - Pending flag readable regardless of mask
// - Acknowledge bit always reads zero
// - Port bit reads zero while enabled
// - Break state blocks software acknowledge unless break clear enable is set
module eil_top
   import eil_pkg::*;
(
   input wire logic REF_CLK_IN,
   input wire logic RST_B_IN,
   input wire logic CE_IN,
   input wire logic IRQ_PIN_B_IN,
   input wire logic VECTOR_FETCH_IN,
   input wire logic BREAK_STATE_IN,
   input wire logic [3:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   output logic CPU_IRQ_REQ_OUT,
   output logic PIN_LEVEL_OUT,
   output logic EVENT_IRQ_OUT
);
   typedef enum logic [2:0] {
      EIL_IDLE = 3'b001,
      EIL_LATCHED = 3'b010,
      EIL_HELD = 3'b100
   } eil_state_t;

   typedef struct packed {
      eil_state_t fsm;
      logic mode;
      logic mask;
      logic fen;
      logic break_clear_enable;
      logic [7:0] rdata;
      logic req;
      logic lvl;
   } eil_top_st_t;

   eil_top_st_t st, next_st;
   eil_bus_t bus;
   logic pin_level, pin_fall;
   logic [1:0] ev, ev_status, ev_mask;
   logic ev_irq;
   logic sw_ack, ack, pend, fall_en;

   assign bus = '{ADDR_IN, WDATA_IN, WR_IN, RD_IN};

   // One write decode shared by control, acknowledge and event strobes
   function automatic logic eil_wr_hit(input eil_bus_t b, input logic [3:0] off);
      return b.wr && eil_hit(b, off);
   endfunction

   logic wr_sc, wr_cfg, wr_ev_clr, wr_ev_mask;
   assign wr_sc = eil_wr_hit(bus, EIL_OFF_STATUS_CONTROL);
   assign wr_cfg = eil_wr_hit(bus, EIL_OFF_CONFIG);
   assign wr_ev_clr = eil_wr_hit(bus, EIL_OFF_IRQ_STATUS);
   assign wr_ev_mask = eil_wr_hit(bus, EIL_OFF_IRQ_MASK);

   eil_pin_sync u_sync (
      .clk_in(REF_CLK_IN),
      .rst_b_in(RST_B_IN),
      .ce_in(CE_IN),
      .pin_b_in(IRQ_PIN_B_IN),
      .level_out(pin_level),
      .fall_out(pin_fall)
   );

   // Software acknowledge is ignored in break unless break clearing is enabled
   assign sw_ack = wr_sc && WDATA_IN[EIL_BIT_ACK]
                   && (!BREAK_STATE_IN || st.break_clear_enable);
   assign ack = VECTOR_FETCH_IN || sw_ack;
   assign fall_en = st.fen && pin_fall;
   assign pend = (st.fsm != EIL_IDLE);

   always_comb begin
      next_st = st;
      ev = 2'h0;
      if (CE_IN) begin
         if (wr_sc) begin
            next_st.mode = WDATA_IN[EIL_BIT_MODE];
            next_st.mask = WDATA_IN[EIL_BIT_MASK];
         end
         if (wr_cfg) begin
            next_st.fen = WDATA_IN[EIL_BIT_FEN];
            next_st.break_clear_enable = WDATA_IN[EIL_BIT_BREAK_CLEAR_ENABLE];
         end
         case (st.fsm)
            EIL_IDLE: begin
               if (fall_en) begin
                  next_st.fsm = EIL_LATCHED;
                  ev[EIL_EV_LATCH] = 1'b1;
               end
            end
            EIL_LATCHED: begin
               if (ack) begin
                  ev[EIL_EV_CLEAR] = 1'b1;
                  // Level mode with pin still low keeps the request alive
                  if (st.mode && !pin_level && st.fen) begin
                     next_st.fsm = EIL_HELD;
                  end else if (fall_en) begin
                     next_st.fsm = EIL_LATCHED;
                  end else begin
                     next_st.fsm = EIL_IDLE;
                  end
               end
            end
            EIL_HELD: begin
               if (!st.mode || pin_level || !st.fen) begin
                  next_st.fsm = EIL_IDLE;
               end
            end
            default: begin
               next_st.fsm = EIL_IDLE;
            end
         endcase
         next_st.rdata = EIL_RD_RESET;
         if (bus.rd) begin
            case (bus.addr)
               EIL_OFF_STATUS_CONTROL: begin
                  // Acknowledge bit position left zero
                  next_st.rdata[EIL_BIT_MODE] = st.mode;
                  next_st.rdata[EIL_BIT_MASK] = st.mask;
                  next_st.rdata[EIL_BIT_PEND] = pend;
               end
               EIL_OFF_CONFIG: begin
                  next_st.rdata[EIL_BIT_FEN] = st.fen;
                  next_st.rdata[EIL_BIT_BREAK_CLEAR_ENABLE] = st.break_clear_enable;
               end
               EIL_OFF_IRQ_STATUS: begin
                  next_st.rdata[1:0] = ev_status;
               end
               EIL_OFF_IRQ_MASK: begin
                  next_st.rdata[1:0] = ev_mask;
               end
               EIL_OFF_PORT: begin
                  next_st.rdata[0] = st.fen ? 1'b0 : pin_level;
               end
               default: begin
                  next_st.rdata = EIL_RD_RESET;
               end
            endcase
         end
         // CPU global mask is applied by the core, not here
         next_st.req = (next_st.fsm != EIL_IDLE) && !next_st.mask;
         next_st.lvl = st.fen ? pin_level : 1'b1;
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         // Reset drops latch and mode even with the pin low
         st <= '{EIL_IDLE, 1'b0, 1'b0, 1'b0, 1'b0, EIL_RD_RESET, 1'b0, 1'b1};
      end else begin
         st <= next_st;
      end
   end

   eil_regs u_regs (
      .clk_in(REF_CLK_IN),
      .rst_b_in(RST_B_IN),
      .ce_in(CE_IN),
      .ev_in(ev),
      .st_clr_wr_in(wr_ev_clr),
      .mask_wr_in(wr_ev_mask),
      .wdata_in(WDATA_IN[1:0]),
      .status_out(ev_status),
      .mask_out(ev_mask),
      .irq_out(ev_irq)
   );

   assign RDATA_OUT = st.rdata;
   assign CPU_IRQ_REQ_OUT = st.req;
   assign PIN_LEVEL_OUT = st.lvl;
   assign EVENT_IRQ_OUT = ev_irq;

   AST_NO_LATCH_DISABLED: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_IDLE && !st.fen) |=> st.fsm == EIL_IDLE)
      else $error("latch set while function disabled");
   AST_EDGE_SETS: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_IDLE && fall_en) |=> st.fsm == EIL_LATCHED)
      else $error("enabled falling edge did not latch");
   AST_VF_CLEARS: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_LATCHED && VECTOR_FETCH_IN && !st.mode && !fall_en) |=> st.fsm == EIL_IDLE)
      else $error("vector fetch did not clear latch");
   AST_SW_ACK: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_LATCHED && sw_ack && !st.mode && !fall_en) |=> !pend)
      else $error("software acknowledge did not clear latch");
   AST_EDGE_HOLD: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (st.fsm == EIL_LATCHED && !ack) |=> st.fsm == EIL_LATCHED)
      else $error("edge request dropped without acknowledge");
   AST_LEVEL_HOLD: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_HELD && st.mode && st.fen && !pin_level) |=> pend)
      else $error("level request dropped while pin low");
   AST_MASK_GATE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      st.req |-> (!st.mask && pend))
      else $error("request presented while masked or not pending");
   AST_BREAK_PROTECT: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (st.fsm == EIL_LATCHED && BREAK_STATE_IN && !st.break_clear_enable && !VECTOR_FETCH_IN) |=> st.fsm == EIL_LATCHED)
      else $error("break state acknowledge changed latch");
   AST_ACK_READS_ZERO: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && RD_IN && ADDR_IN == EIL_OFF_STATUS_CONTROL) |=> !RDATA_OUT[EIL_BIT_ACK])
      else $error("acknowledge bit read as one");

   // Register port: writes land one edge later, reads stand for one cycle only
   AST_MODE_WRITE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && wr_sc) |=> st.mode == $past(WDATA_IN[EIL_BIT_MODE]))
      else $error("mode bit did not take the written value");
   AST_MASK_WRITE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && wr_sc) |=> st.mask == $past(WDATA_IN[EIL_BIT_MASK]))
      else $error("module mask did not take the written value");
   AST_FEN_WRITE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && wr_cfg) |=> st.fen == $past(WDATA_IN[EIL_BIT_FEN]))
      else $error("function enable did not take the written value");
   AST_BREAK_CLEAR_ENABLE_WRITE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && wr_cfg) |=> st.break_clear_enable == $past(WDATA_IN[EIL_BIT_BREAK_CLEAR_ENABLE]))
      else $error("break clear enable did not take the written value");
   AST_MODE_KEPT: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && !wr_sc) |=> $stable(st.mode))
      else $error("mode bit changed without a write");
   AST_PEND_READ: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && RD_IN && ADDR_IN == EIL_OFF_STATUS_CONTROL) |=> RDATA_OUT[EIL_BIT_PEND] == $past(pend))
      else $error("pending flag read differs from latch state");
   AST_PORT_ZERO: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && RD_IN && ADDR_IN == EIL_OFF_PORT && st.fen) |=> RDATA_OUT == 8'h00)
      else $error("port bit read nonzero while function enabled");
   AST_PORT_LEVEL: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && RD_IN && ADDR_IN == EIL_OFF_PORT && !st.fen) |=> RDATA_OUT[0] == $past(pin_level))
      else $error("port bit read differs from pin while function disabled");
   AST_READ_IDLE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && !RD_IN) |=> RDATA_OUT == 8'h00)
      else $error("read data nonzero without a read");
   AST_UNMAPPED_READ: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && RD_IN && ADDR_IN > EIL_OFF_PORT) |=> RDATA_OUT == 8'h00)
      else $error("unmapped address read nonzero");

   // Latch: in edge mode a new edge beats a simultaneous acknowledge so no request is lost
   AST_EDGE_EVENT: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_IDLE && fall_en) |=> ev_status[EIL_EV_LATCH])
      else $error("latch event not recorded");
   AST_ACK_EVENT: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_LATCHED && ack) |=> ev_status[EIL_EV_CLEAR])
      else $error("clear event not recorded");
   AST_REFIRE_WINS: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_LATCHED && ack && fall_en && !st.mode) |=> st.fsm == EIL_LATCHED)
      else $error("edge coinciding with acknowledge was lost");
   AST_IDLE_NEEDS_EDGE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_IDLE && !fall_en) |=> st.fsm == EIL_IDLE)
      else $error("latch set without an enabled edge");
   AST_IDLE_NOT_HELD: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (st.fsm == EIL_IDLE) |=> st.fsm != EIL_HELD)
      else $error("held state entered without a latched request");
   AST_LEVEL_ACK_LOW: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_LATCHED && ack && st.mode && st.fen && !pin_level) |=> st.fsm == EIL_HELD)
      else $error("level request dropped on acknowledge with pin low");
   AST_LEVEL_RELEASE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_HELD && pin_level) |=> st.fsm == EIL_IDLE)
      else $error("held request kept after pin returned high");
   AST_LEVEL_ACK_HIGH: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_LATCHED && ack && st.mode && pin_level) |=> st.fsm == EIL_IDLE)
      else $error("acknowledge with pin high did not clear level request");
   AST_HELD_EDGE_MODE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_HELD && !st.mode) |=> st.fsm == EIL_IDLE)
      else $error("held request kept in edge mode");
   AST_HELD_DISABLED: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_HELD && !st.fen) |=> st.fsm == EIL_IDLE)
      else $error("held request kept with function disabled");
   AST_HELD_ACK_NO_EFFECT: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_HELD && st.mode && st.fen && !pin_level && ack) |=> st.fsm == EIL_HELD)
      else $error("acknowledge released a request with pin low");
   AST_BREAK_CLEAR_EN: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fsm == EIL_LATCHED && BREAK_STATE_IN && st.break_clear_enable && sw_ack && !st.mode && !fall_en)
         |=> st.fsm == EIL_IDLE)
      else $error("enabled break acknowledge did not clear latch");

   // Outputs and freeze
   AST_REQ_UNMASKED: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (pend && !st.mask) |-> st.req)
      else $error("unmasked pending request not presented");
   AST_LVL_DISABLED: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && !st.fen) |=> PIN_LEVEL_OUT)
      else $error("pin level shown low while function disabled");
   AST_LVL_ENABLED: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && st.fen) |=> PIN_LEVEL_OUT == $past(pin_level))
      else $error("pin level output differs from synchronised pin");
   AST_EVENT_IRQ_OFF: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      ev_irq |-> (|(ev_status & ev_mask)))
      else $error("event interrupt high with no unmasked event");
   AST_EVENT_IRQ_ON: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (|(ev_status & ev_mask)) |-> ev_irq)
      else $error("unmasked event without event interrupt");
   AST_EVENT_CLEAR: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      (CE_IN && wr_ev_clr && WDATA_IN[EIL_EV_LATCH] && !(st.fsm == EIL_IDLE && fall_en))
         |=> !ev_status[EIL_EV_LATCH])
      else $error("latch event not cleared by write one");
   AST_FREEZE: assert property (@(posedge REF_CLK_IN) disable iff (!RST_B_IN)
      !CE_IN |=> $stable(st))
      else $error("state changed while clock enable low");
endmodule

// ===== sim/eil_pin_src.sv
// Behavioural external interrupt source on the active-low pin.
// Assumes the pin has a pull-up, so a released line reads high.
`timescale 1ns/1ns
module eil_pin_src (
   input wire logic clk_in,
   input wire logic hold_low_in,
   output logic pin_b_out
);
   // Starts released so the pin never shows an unknown level
   initial pin_b_out = 1'b1;
   // Pulls the line low on command; the pull-up wins once released
   always @(posedge clk_in) begin
      pin_b_out <= hold_low_in ? 1'b0 : 1'b1;
   end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the external interrupt pin latch.
// Assumes the pin source model and the register map of the package.
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %0t got %h exp %h", $time, g, e); end end
module testbench;
   import eil_pkg::*;
   typedef struct packed {logic mode; logic mask; logic exp_req; logic exp_held;} eil_row_t;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic vf = 1'b0;
   logic brk = 1'b0;
   logic ce = 1'b1;
   logic wr_st = 1'b0;
   logic rd_st = 1'b0;
   logic hold_low = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [7:0] d;
   logic pin_b, req, lvl, ev_irq;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   eil_row_t rows [4] = '{'{1'b0, 1'b0, 1'b1, 1'b0}, '{1'b0, 1'b1, 1'b0, 1'b0},
                          '{1'b1, 1'b0, 1'b1, 1'b1}, '{1'b1, 1'b1, 1'b0, 1'b1}};
   always #2 clk = ~clk;
   eil_pin_src src (.clk_in(clk), .hold_low_in(hold_low), .pin_b_out(pin_b));
   eil_top dut (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce), .IRQ_PIN_B_IN(pin_b),
      .VECTOR_FETCH_IN(vf), .BREAK_STATE_IN(brk), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr_st), .RD_IN(rd_st), .RDATA_OUT(rdata), .CPU_IRQ_REQ_OUT(req),
      .PIN_LEVEL_OUT(lvl), .EVENT_IRQ_OUT(ev_irq));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      wr_st <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr_st <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      rd_st <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_st <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic pin(input logic low, input int n);
      hold_low <= low;
      cyc(n);
   endtask
   task automatic close_out;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Generous ceiling: the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      cyc(2);
      bus_rd(EIL_OFF_STATUS_CONTROL, d);
      `CHK(d, 8'h00)
      bus_rd(4'hf, d);
      `CHK(d, 8'h00)
      pin(1'b1, 7);
      `CHK(req, 1'b0)
      `CHK(lvl, 1'b1)
      bus_rd(EIL_OFF_PORT, d);
      `CHK(d, 8'h00)
      pin(1'b0, 4);
      bus_rd(EIL_OFF_PORT, d);
      `CHK(d, 8'h01)
      bus_wr(EIL_OFF_CONFIG, 8'h01);
      bus_wr(EIL_OFF_IRQ_MASK, 8'h01);
      bus_rd(EIL_OFF_PORT, d);
      `CHK(d, 8'h00)
      foreach (rows[i]) begin
         bus_wr(EIL_OFF_STATUS_CONTROL, {6'h0, rows[i].mask, rows[i].mode});
         pin(1'b1, 7);
         `CHK(req, rows[i].exp_req)
         bus_rd(EIL_OFF_STATUS_CONTROL, d);
         `CHK(d, {4'h0, 1'b1, 1'b0, rows[i].mask, rows[i].mode})
         bus_wr(EIL_OFF_STATUS_CONTROL, {5'h0, 1'b1, rows[i].mask, rows[i].mode});
         cyc(2);
         `CHK(req, rows[i].exp_held & rows[i].exp_req)
         pin(1'b0, 6);
         `CHK(req, 1'b0)
      end
      `CHK(ev_irq, 1'b1)
      bus_rd(EIL_OFF_IRQ_STATUS, d);
      `CHK(d, 8'h03)
      bus_wr(EIL_OFF_IRQ_STATUS, 8'h03);
      cyc(2);
      `CHK(ev_irq, 1'b0)
      // Break with clear enable off: only the vector fetch may clear; with it on, a software acknowledge clears
      bus_wr(EIL_OFF_STATUS_CONTROL, 8'h00);
      pin(1'b1, 7);
      @(posedge clk);
      brk <= 1'b1;
      bus_wr(EIL_OFF_STATUS_CONTROL, 8'h04);
      cyc(2);
      `CHK(req, 1'b1)
      @(posedge clk);
      vf <= 1'b1;
      @(posedge clk);
      vf <= 1'b0;
      cyc(2);
      `CHK(req, 1'b0)
      pin(1'b0, 4);
      pin(1'b1, 7);
      bus_wr(EIL_OFF_CONFIG, 8'h03);
      bus_wr(EIL_OFF_STATUS_CONTROL, 8'h04);
      cyc(2);
      `CHK(req, 1'b0)
      @(posedge clk);
      brk <= 1'b0;
      // Level mode, pin returns high before the acknowledge
      bus_wr(EIL_OFF_STATUS_CONTROL, 8'h01);
      pin(1'b0, 4);
      pin(1'b1, 7);
      pin(1'b0, 6);
      `CHK(req, 1'b1)
      bus_wr(EIL_OFF_STATUS_CONTROL, 8'h05);
      cyc(2);
      `CHK(req, 1'b0)
      pin(1'b1, 7);
      `CHK(req, 1'b1)
      `CHK(lvl, 1'b0)
      // Frozen block ignores an acknowledge written while the enable is low
      @(posedge clk);
      ce <= 1'b0;
      bus_wr(EIL_OFF_STATUS_CONTROL, 8'h04);
      @(posedge clk);
      ce <= 1'b1;
      cyc(2);
      `CHK(req, 1'b1)
      bus_rd(EIL_OFF_STATUS_CONTROL, d);
      `CHK(d, 8'h09)
      @(posedge clk);
      rst_b <= 1'b0;
      cyc(2);
      `CHK(req, 1'b0)
      `CHK(lvl, 1'b1)
      @(posedge clk);
      rst_b <= 1'b1;
      cyc(10);
      `CHK(req, 1'b0)
      bus_rd(EIL_OFF_STATUS_CONTROL, d);
      `CHK(d, 8'h00)
      // Pin stayed low through reset: re-enabling sees no edge, so nothing latches
      bus_wr(EIL_OFF_CONFIG, 8'h01);
      cyc(6);
      `CHK(req, 1'b0)
      `CHK(lvl, 1'b0)
      close_out();
   end
endmodule
